// >>> hw/nio_port_bit.v
// Purpose: One port bit: direction, output latch, pin drive and read-back.
// Assumes: Synchronised pin level arrives on pinSync.
// Notes: A masked-off bit neither drives nor reads.
`timescale 1ns/100ps
module nio_port_bit (
  input wire ioEnable,
  input wire dirOut,
  input wire latchVal,
  input wire pinSync,
  output wire padOut,
  output wire padOeN,
  output wire readVal
);
  // Only an enabled output bit drives; reads follow the latch for outputs.
  assign padOut = latchVal;
  assign padOeN = ~(ioEnable & dirOut);
  assign readVal = ioEnable & (dirOut ? latchVal : pinSync);
endmodule // nio_port_bit

// >>> hw/nio_ports.v
// Purpose: Three 4-bit general purpose ports with direction, latch,
//   pull-low control, low-level hold on the third port and a pseudo
//   serial output mode on the first port.
// Assumes: Avalon-MM slave on ref_clk, synchronous active-high reset.
// Notes: Mask options are parameters; pins are split into in, out, oe_n.
//   Unused byte lanes are ignored; a serial write during a strobe gives no new strobe.
`timescale 1ns/100ps
`include "nio_regs.vh"
module nio_ports #(
  parameter [3:0] IO_MASK_A = 4'hf,
  parameter [3:0] IO_MASK_B = 4'hf,
  parameter [3:0] IO_MASK_C = 4'hf,
  parameter PULL_OPT_A = 1,
  parameter PULL_OPT_B = 1,
  parameter PULL_OPT_C = 1,
  parameter HOLD_OPT_C = 1
) (
  input wire ref_clk,
  input wire rst,
  input wire clkEn,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [3:0] portAIn,
  output wire [3:0] portAOut,
  output wire [3:0] portAOeN,
  output wire [3:0] portAPullEn,
  input wire [3:0] portBIn,
  output wire [3:0] portBOut,
  output wire [3:0] portBOeN,
  output wire [3:0] portBPullEn,
  input wire [3:0] portCIn,
  output wire [3:0] portCOut,
  output wire [3:0] portCOeN,
  output wire [3:0] portCPullEn,
  output wire [3:0] portCHoldEn
);
  // Serial strobe sequencer. GAP holds the pulse back one cycle so that the
  // data and constant bits are already steady when bit three rises.
  localparam SER_IDLE = 2'b00;
  localparam SER_PULSE = 2'b01;
  localparam SER_GAP = 2'b10;

  // Architectural state; all of it freezes while clkEn is low.
  reg [3:0] dirA_reg;
  reg [3:0] dirB_reg;
  reg [3:0] dirC_reg;
  reg [3:0] latA_reg;
  reg [3:0] latB_reg;
  reg [3:0] latC_reg;
  reg pullA_reg;
  reg pullB_reg;
  reg pullC_reg;
  reg serEn_reg;
  reg serConst_reg;
  reg [1:0] serData_reg;
  reg [1:0] serState_reg;
  reg [1:0] serState_next;
  reg [7:0] serCnt_reg;
  reg [7:0] serCnt_next;
  reg serPulse_reg;
  reg respDone_reg;
  // Synchronised pins, per-bit read values and bus qualifiers.
  wire [3:0] pinASync;
  wire [3:0] pinBSync;
  wire [3:0] pinCSync;
  wire [3:0] readA;
  wire [3:0] readB;
  wire [3:0] readC;
  wire [3:0] driveA;
  wire [3:0] maskA;
  wire [3:0] maskB;
  wire [3:0] maskC;
  wire busReq;
  wire busWr;
  wire lowLane;
  wire [3:0] wrNib;

  // Mask options fold in as constants; a cleared bit is not a port bit at all.
  assign maskA = IO_MASK_A;
  assign maskB = IO_MASK_B;
  assign maskC = IO_MASK_C;

  // Pins come from outside the clock domain and are synchronised first.
  // Pin reads therefore lag the pins by two cycles.
  nio_sync #(.WIDTH(4)) uSyncA (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .asyncIn(portAIn),
    .syncOut(pinASync)
  );
  nio_sync #(.WIDTH(4)) uSyncB (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .asyncIn(portBIn),
    .syncOut(pinBSync)
  );
  nio_sync #(.WIDTH(4)) uSyncC (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .asyncIn(portCIn),
    .syncOut(pinCSync)
  );

  // Every access takes one wait cycle, then completes on the next edge.
  // While clkEn is low the bus stalls with waitrequest high, so a master never
  // sees an answer that the frozen registers did not take.
  assign busReq = avs_read | avs_write;
  assign avs_waitrequest = busReq & (~respDone_reg | ~clkEn);
  assign busWr = avs_write & respDone_reg & clkEn;
  assign lowLane = avs_byteenable[0];
  assign wrNib = avs_writedata[3:0];

  // Marks the answer cycle of an access and drops again as it completes, so
  // back-to-back requests cost two cycles each.
  always @(posedge ref_clk) begin
    if (rst) begin
      respDone_reg <= 1'b0;
    end else if (clkEn) begin
      respDone_reg <= busReq & ~respDone_reg;
    end
  end

  // Direction and pull control; reset leaves all ports as inputs.
  // Pull control is one bit per port and only ever acts on input bits.
  // Writes with byte lane zero off are refused, since the nibble lives there.
  always @(posedge ref_clk) begin
    if (rst) begin
      dirA_reg <= `NIO_DIR_RESET;
      dirB_reg <= `NIO_DIR_RESET;
      dirC_reg <= `NIO_DIR_RESET;
      pullA_reg <= 1'b1;
      pullB_reg <= 1'b1;
      pullC_reg <= 1'b1;
    end else if (busWr && lowLane) begin
      if (avs_address == `NIO_OFF_DIR_A) begin
        dirA_reg <= wrNib;
        pullA_reg <= avs_writedata[`NIO_DIR_PULL_BIT];
      end else if (avs_address == `NIO_OFF_DIR_B) begin
        dirB_reg <= wrNib;
        pullB_reg <= avs_writedata[`NIO_DIR_PULL_BIT];
      end else if (avs_address == `NIO_OFF_DIR_C) begin
        dirC_reg <= wrNib;
        pullC_reg <= avs_writedata[`NIO_DIR_PULL_BIT];
      end
    end
  end

  // Output latches. They may be written while a bit is still an input, which is
  // how software preloads a value before turning the pin round without a glitch.
  always @(posedge ref_clk) begin
    if (rst) begin
      latA_reg <= `NIO_LAT_RESET;
      latB_reg <= `NIO_LAT_RESET;
      latC_reg <= `NIO_LAT_RESET;
    end else if (busWr && lowLane) begin
      if (avs_address == `NIO_OFF_LAT_A) begin
        latA_reg <= wrNib;
      end else if (avs_address == `NIO_OFF_LAT_B) begin
        latB_reg <= wrNib;
      end else if (avs_address == `NIO_OFF_LAT_C) begin
        latC_reg <= wrNib;
      end
    end
  end

  // Serial mode register: data bits, constant bit and enable.
  // Writing with the enable bit clear leaves serial mode; the latch shows again.
  always @(posedge ref_clk) begin
    if (rst) begin
      serEn_reg <= 1'b0;
      serConst_reg <= 1'b0;
      serData_reg <= 2'b00;
    end else if (busWr && lowLane && avs_address == `NIO_OFF_SER_A) begin
      serData_reg <= avs_writedata[`NIO_SER_DATA_LSB+1:`NIO_SER_DATA_LSB];
      serConst_reg <= avs_writedata[`NIO_SER_CONST_BIT];
      serEn_reg <= avs_writedata[`NIO_SER_EN_BIT];
    end
  end

  // Each serial write with the enable bit set fires one bit-three pulse of fixed width,
  // so a receiver can clock bits 0..2 on its rising edge.
  // A write that lands while a strobe runs starts no new one, so serial writes
  // must be spaced at least four cycles apart.
  always @* begin
    serState_next = serState_reg;
    serCnt_next = serCnt_reg;
    case (serState_reg)
      SER_IDLE: begin
        if (busWr && lowLane && avs_address == `NIO_OFF_SER_A &&
            avs_writedata[`NIO_SER_EN_BIT]) begin
          serState_next = SER_GAP;
          serCnt_next = `NIO_PULSE_CYCLES;
        end
      end
      SER_GAP: begin
        serState_next = SER_PULSE; // Data settles one cycle before the pulse.
        serCnt_next = `NIO_PULSE_CYCLES;
      end
      SER_PULSE: begin
        if (serCnt_reg == 8'h01) begin
          serState_next = SER_IDLE;
          serCnt_next = 8'h00;
        end else begin
          serCnt_next = serCnt_reg - 8'h01;
        end
      end
      default: begin
        // Unused code: fall back to idle.
        serState_next = SER_IDLE;
        serCnt_next = 8'h00;
      end
    endcase
  end

  // Sequencer registers; the strobe is registered so bit three never glitches.
  always @(posedge ref_clk) begin
    if (rst) begin
      serState_reg <= SER_IDLE;
      serCnt_reg <= 8'h00;
      serPulse_reg <= 1'b0;
    end else if (clkEn) begin
      serState_reg <= serState_next;
      serCnt_reg <= serCnt_next;
      serPulse_reg <= (serState_next == SER_PULSE);
    end
  end

  // In serial mode the first port shows data, constant and pulse.
  // Outside it the latch drives, so leaving serial mode restores the last write.
  assign driveA = serEn_reg ? {serPulse_reg, serConst_reg, serData_reg} : latA_reg;

  // Per-bit port logic for all three ports, bit i is pin i+1.
  genvar i;
  generate
    // One shared bit cell keeps the three ports from drifting apart.
    for (i = 0; i < 4; i = i + 1) begin : gBit
      nio_port_bit uA (
        .ioEnable(maskA[i]),
        .dirOut(dirA_reg[i]),
        .latchVal(driveA[i]),
        .pinSync(pinASync[i]),
        .padOut(portAOut[i]),
        .padOeN(portAOeN[i]),
        .readVal(readA[i])
      );
      nio_port_bit uB (
        .ioEnable(maskB[i]),
        .dirOut(dirB_reg[i]),
        .latchVal(latB_reg[i]),
        .pinSync(pinBSync[i]),
        .padOut(portBOut[i]),
        .padOeN(portBOeN[i]),
        .readVal(readB[i])
      );
      nio_port_bit uC (
        .ioEnable(maskC[i]),
        .dirOut(dirC_reg[i]),
        .latchVal(latC_reg[i]),
        .pinSync(pinCSync[i]),
        .padOut(portCOut[i]),
        .padOeN(portCOeN[i]),
        .readVal(readC[i])
      );
      // Pull devices only on input bits of enabled, optioned pins.
      // An output never carries a sink, which would fight the driven level.
      assign portAPullEn[i] = (PULL_OPT_A != 0) & maskA[i] & pullA_reg & ~dirA_reg[i];
      assign portBPullEn[i] = (PULL_OPT_B != 0) & maskB[i] & pullB_reg & ~dirB_reg[i];
      assign portCPullEn[i] = (PULL_OPT_C != 0) & maskC[i] & pullC_reg & ~dirC_reg[i];
      // Hold needs the pull-low option too, and is off for outputs.
      // Hold and pull are exclusive by construction: one pull bit picks either.
      assign portCHoldEn[i] = (PULL_OPT_C != 0) & (HOLD_OPT_C != 0) & maskC[i] &
        ~pullC_reg & ~dirC_reg[i];
    end
  endgenerate

  // Read data is registered; unmapped addresses return zero.
  // It is captured in the waiting cycle and stands until the next read, so the
  // master finds it steady at the edge where waitrequest is low.
  always @(posedge ref_clk) begin
    if (rst) begin
      avs_readdata <= `NIO_UNMAPPED_DATA;
    end else if (clkEn && avs_read && !respDone_reg) begin
      if (avs_address == `NIO_OFF_DIR_A) begin
        avs_readdata <= {27'h0, pullA_reg, dirA_reg};
      end else if (avs_address == `NIO_OFF_LAT_A) begin
        avs_readdata <= {28'h0, latA_reg};
      end else if (avs_address == `NIO_OFF_PIN_A) begin
        avs_readdata <= {28'h0, readA};
      end else if (avs_address == `NIO_OFF_SER_A) begin
        avs_readdata <= {28'h0, serEn_reg, serConst_reg, serData_reg};
      end else if (avs_address == `NIO_OFF_DIR_B) begin
        avs_readdata <= {27'h0, pullB_reg, dirB_reg};
      end else if (avs_address == `NIO_OFF_LAT_B) begin
        avs_readdata <= {28'h0, latB_reg};
      end else if (avs_address == `NIO_OFF_PIN_B) begin
        avs_readdata <= {28'h0, readB};
      end else if (avs_address == `NIO_OFF_DIR_C) begin
        avs_readdata <= {27'h0, pullC_reg, dirC_reg};
      end else if (avs_address == `NIO_OFF_LAT_C) begin
        avs_readdata <= {28'h0, latC_reg};
      end else if (avs_address == `NIO_OFF_PIN_C) begin
        avs_readdata <= {28'h0, readC};
      end else if (avs_address == `NIO_OFF_STAT) begin
        avs_readdata <= {30'h0, serPulse_reg, serEn_reg};
      end else begin
        avs_readdata <= `NIO_UNMAPPED_DATA;
      end
    end
  end
endmodule // nio_ports

// >>> hw/nio_regs.vh
// Purpose: Register map, field positions and reset values of the nibble port block.
// Assumes: Avalon-MM slave with 32-bit data, word aligned byte addresses.
// Notes: Definitions only.
`ifndef NIO_REGS_VH
`define NIO_REGS_VH
`define NIO_ADDR_W 6
`define NIO_OFF_DIR_A 6'h00
`define NIO_OFF_LAT_A 6'h04
`define NIO_OFF_PIN_A 6'h08
`define NIO_OFF_SER_A 6'h0c
`define NIO_OFF_DIR_B 6'h10
`define NIO_OFF_LAT_B 6'h14
`define NIO_OFF_PIN_B 6'h18
`define NIO_OFF_DIR_C 6'h20
`define NIO_OFF_LAT_C 6'h24
`define NIO_OFF_PIN_C 6'h28
`define NIO_OFF_STAT 6'h30
`define NIO_DIR_PULL_BIT 4
`define NIO_SER_DATA_LSB 0
`define NIO_SER_CONST_BIT 2
`define NIO_SER_EN_BIT 3
`define NIO_DIR_RESET 4'h0
`define NIO_LAT_RESET 4'h0
`define NIO_PULSE_CYCLES 8'h02
`define NIO_UNMAPPED_DATA 32'h0000_0000
`endif

// >>> hw/nio_sync.v
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Pins are asynchronous to ref_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module nio_sync #(
  parameter WIDTH = 4
) (
  input wire ref_clk,
  input wire rst,
  input wire clkEn,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // Two stages keep metastability away from the port logic.
  always @(posedge ref_clk) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
    end
  end

  assign syncOut = sync_reg;
endmodule // nio_sync

// >>> tb/nio_pin_model.sv
// Purpose: Pin side of one 4-bit port: switches, pull-low and hold.
// Assumes: The design drives a pin only while its padOeN bit is low.
// Notes: A released pin with no switch enabled and no sink shows the inverse of the switch value.
`timescale 1ns/100ps
module nio_pin_model (
  input wire [3:0] padOut,
  input wire [3:0] padOeN,
  input wire [3:0] pullEn,
  input wire [3:0] holdEn,
  input wire [3:0] swVal,
  input wire [3:0] swEn,
  output logic [3:0] pin
);
  // Design drive wins; a floating pin never repeats a stale level by luck.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin[i] = !padOeN[i] ? padOut[i] : swEn[i] ? swVal[i] :
        (pullEn[i] | holdEn[i]) ? 1'b0 : ~swVal[i];
    end
  end
endmodule // nio_pin_model

// >>> tb/nio_ports_properties.sv
// Purpose: Port-level checks of the nibble port block.
// Assumes: Default mask options, all bits are port bits.
// Notes: Bound to every nio_ports instance.
`timescale 1ns/100ps
`include "nio_regs.vh"
module nio_ports_properties (
  input wire ref_clk,
  input wire rst,
  input wire clkEn,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire avs_waitrequest,
  input wire [3:0] portAOut,
  input wire [3:0] portAOeN,
  input wire [3:0] portBOut,
  input wire [3:0] portBOeN,
  input wire [3:0] portCOeN,
  input wire [3:0] portCPullEn,
  input wire [3:0] portCHoldEn
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [31:0] wdPrev;
  wire take = avs_write && !avs_waitrequest && avs_byteenable[0] && clkEn;
  // Keeps last cycle's write data so checks can compare without slicing $past.
  always @(posedge ref_clk) begin
    wdPrev <= avs_writedata;
  end
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest && clkEn
    |=> !avs_waitrequest) else $error("Bus stall longer than one cycle.");
  a_reset_state: assert property ($past(rst) |-> portAOeN == 4'hf
    && portBOeN == 4'hf
    && portCOeN == 4'hf && portCPullEn == 4'hf && portCHoldEn == 4'h0)
    else $error("Ports not in input mode after reset.");
  a_c_out_free: assert property ((~portCOeN & (portCPullEn | portCHoldEn)) == 4'h0)
    else $error("Port C output bit has pull or hold on.");
  a_c_one_sink: assert property ((portCPullEn & portCHoldEn) == 4'h0)
    else $error("Port C pull and hold on together.");
  a_dir_c: assert property (take && avs_address == `NIO_OFF_DIR_C |=>
    portCOeN == ~wdPrev[3:0] && portCPullEn == (wdPrev[4] ? ~wdPrev[3:0] : 4'h0)
    && portCHoldEn == (wdPrev[4] ? 4'h0 : ~wdPrev[3:0])) else $error("Port C direction wrong.");
  a_dir_a: assert property (take && avs_address == `NIO_OFF_DIR_A |=>
    portAOeN == ~wdPrev[3:0]) else $error("Port A direction wrong.");
  a_dir_b: assert property (take && avs_address == `NIO_OFF_DIR_B |=>
    portBOeN == ~wdPrev[3:0]) else $error("Port B direction wrong.");
  a_latch_b: assert property (take && avs_address == `NIO_OFF_LAT_B |=>
    portBOut == wdPrev[3:0]) else $error("Port B latch not driven.");
  a_serial_pulse: assert property (take && avs_address == `NIO_OFF_SER_A
    && avs_writedata[3] && portAOeN == 4'h0 |=> portAOut[2:0] == wdPrev[2:0] && !portAOut[3]
    ##1 portAOut[3] ##1 portAOut[3] ##1 !portAOut[3]) else $error("Serial frame wrong.");
  c_serial: cover property (take && avs_address == `NIO_OFF_SER_A);
  c_hold: cover property (portCHoldEn != 4'h0);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule // nio_ports_properties
bind nio_ports nio_ports_properties chk_i (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .portAOut(portAOut), .portAOeN(portAOeN),
  .portBOut(portBOut), .portBOeN(portBOeN), .portCOeN(portCOeN),
  .portCPullEn(portCPullEn), .portCHoldEn(portCHoldEn));

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the nibble port block.
// Assumes: Default mask options; clkEn held high.
// Notes: Each access is one Avalon-MM transfer; checks run at the falling edge.
`timescale 1ns/100ps
`include "nio_regs.vh"
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] addr = 6'h00;
  logic rdEn = 1'b0;
  logic wrEn = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata, got, cnt;
  wire waitReq;
  logic [2:0][3:0] sw = 12'h000;
  logic [2:0][3:0] swEn = 12'h000;
  wire [2:0][3:0] pin;
  wire [2:0][3:0] out;
  wire [2:0][3:0] oeN;
  wire [2:0][3:0] pull;
  wire [3:0] holdC;
  int n_errors = 0;
  int checks = 0;
  nio_ports uut (.ref_clk(ref_clk), .rst(rst), .clkEn(1'b1), .avs_address(addr),
    .avs_read(rdEn), .avs_write(wrEn), .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(waitReq),
    .portAIn(pin[0]), .portAOut(out[0]), .portAOeN(oeN[0]), .portAPullEn(pull[0]),
    .portBIn(pin[1]), .portBOut(out[1]), .portBOeN(oeN[1]), .portBPullEn(pull[1]),
    .portCIn(pin[2]), .portCOut(out[2]), .portCOeN(oeN[2]), .portCPullEn(pull[2]),
    .portCHoldEn(holdC));
  nio_pin_model pa (.padOut(out[0]), .padOeN(oeN[0]), .pullEn(pull[0]), .holdEn(4'h0),
    .swVal(sw[0]), .swEn(swEn[0]), .pin(pin[0]));
  nio_pin_model pb (.padOut(out[1]), .padOeN(oeN[1]), .pullEn(pull[1]), .holdEn(4'h0),
    .swVal(sw[1]), .swEn(swEn[1]), .pin(pin[1]));
  nio_pin_model pc (.padOut(out[2]), .padOeN(oeN[2]), .pullEn(pull[2]), .holdEn(holdC),
    .swVal(sw[2]), .swEn(swEn[2]), .pin(pin[2]));
  // Free-running 100 MHz clock.
  initial forever #5 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One transfer, held until waitrequest is seen low; ends mid-cycle so outputs settle.
  task automatic xfer(input logic isWr, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wrEn <= isWr;
    rdEn <= !isWr;
    @(posedge ref_clk);
    while (waitReq) @(posedge ref_clk);
    got = rdata;
    wrEn <= 1'b0;
    rdEn <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // A hung handshake ends the run here.
  initial begin
    #100000;
    n_errors++;
    results();
  end
  // Main sequence: reset, per-port direction and read-back, port C sinks, serial frame.
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk({oeN[0], oeN[1], oeN[2]}, 12'hfff);
    chk({pull[2], holdC}, 8'hf0);
    xfer(1'b0, 6'h1c, 32'h0);
    chk(got, `NIO_UNMAPPED_DATA);
    for (int p = 0; p < 3; p++) begin
      sw[p] <= 4'ha;
      swEn[p] <= 4'hf;
      xfer(1'b1, 6'(p * 16 + 4), 32'h5);
      xfer(1'b1, 6'(p * 16), 32'h13);
      @(posedge ref_clk);
      be <= 4'h0;
      xfer(1'b1, 6'(p * 16 + 4), 32'ha);
      @(posedge ref_clk);
      be <= 4'hf;
      repeat (3) @(posedge ref_clk);
      xfer(1'b0, 6'(p * 16 + 8), 32'h0);
      chk(got[3:0], 4'h9);
      chk(oeN[p] | out[p], 4'hd);
      chk(pull[p], 4'hc);
      xfer(1'b0, 6'(p * 16 + 4), 32'h0);
      chk(got, 32'h5);
      xfer(1'b0, 6'(p * 16), 32'h0);
      chk(got, 32'h13);
    end
    chk({pull[2], holdC}, 8'hc0);
    xfer(1'b1, `NIO_OFF_DIR_C, 32'h3);
    chk({pull[2], holdC}, 8'h0c);
    xfer(1'b1, `NIO_OFF_DIR_B, 32'h0);
    chk(pull[1], 4'h0);
    swEn[2] <= 4'h0;
    repeat (3) @(posedge ref_clk);
    xfer(1'b0, `NIO_OFF_PIN_C, 32'h0);
    chk(got[3:0], 4'h1);
    xfer(1'b1, `NIO_OFF_LAT_A, 32'h0);
    xfer(1'b1, `NIO_OFF_DIR_A, 32'hf);
    xfer(1'b1, `NIO_OFF_SER_A, 32'hd);
    chk(out[0][2:0], 3'h5);
    cnt = 32'h0;
    repeat (8) begin
      @(negedge ref_clk);
      cnt = cnt + out[0][3];
    end
    chk(cnt, 32'h2);
    xfer(1'b0, `NIO_OFF_STAT, 32'h0);
    chk(got, 32'h1);
    xfer(1'b0, `NIO_OFF_SER_A, 32'h0);
    chk(got, 32'hd);
    xfer(1'b1, `NIO_OFF_SER_A, 32'h0);
    chk(out[0], 4'h0);
    results();
  end
endmodule // testbench
